/* hw/dnd_pkg.sv */
// Constants and carrier types of the drive network input decoder
package dnd_pkg;
  localparam logic [7:0]  OFS_SPD      = 8'h00;
  localparam logic [7:0]  OFS_SCALE    = 8'h04;
  localparam logic [7:0]  OFS_NOM      = 8'h08;
  localparam logic [7:0]  OFS_DEFSCALE = 8'h0c;
  localparam logic [7:0]  OFS_LINK     = 8'h10;
  localparam logic [7:0]  OFS_OPCMD    = 8'h14;
  localparam logic [7:0]  OFS_FREQ     = 8'h18;
  localparam logic [7:0]  OFS_RDCODE   = 8'h1c;
  localparam logic [7:0]  OFS_RDVAL    = 8'h20;
  localparam logic [7:0]  OFS_WRCODE   = 8'h24;
  localparam logic [7:0]  OFS_WRDATA   = 8'h28;
  localparam logic [7:0]  OFS_AO       = 8'h2c;
  localparam logic [7:0]  OFS_DO1      = 8'h30;
  localparam logic [7:0]  OFS_DO2      = 8'h34;
  localparam logic [7:0]  OFS_FWD      = 8'h38;
  localparam logic [7:0]  OFS_STATUS   = 8'h3c;
  localparam logic [7:0]  RST_SP_STATE = 8'hff;
  localparam logic [7:0]  RST_SP_VALUE = 8'h00;
  localparam logic [15:0] RST_DEFSCALE = 16'h4e20;
  localparam logic [15:0] RST_NOM      = 16'h01f4;
  localparam logic [7:0]  RST_LINK     = 8'h00;
  localparam logic [15:0] RST_ZERO     = 16'h0000;
  localparam logic [7:0]  SW_INVALID   = 8'hff;
  localparam logic [7:0]  SW_ON        = 8'h01;
  localparam logic [15:0] SCALE_BAD    = 16'h7fff;
  localparam logic [15:0] FREQ_MAX     = 16'h0fa0;
  localparam logic [15:0] AO_MAX       = 16'h55f0;
  localparam logic [7:0]  FN_AO        = 8'h0a;
  localparam logic [7:0]  FN_DO        = 8'h1b;
  localparam logic [7:0]  LF_FREQ      = 8'h01;
  localparam logic [7:0]  LF_OPCMD     = 8'h02;
  localparam logic [7:0]  LF_ALL       = 8'h03;
  localparam logic [39:0] FREQ_DIV     = 40'h00_003d_0900;
  localparam int          ALM_BIT      = 15;

  typedef struct packed {
    logic [7:0] link_function_code;
    logic [7:0] analog_output_a_function;
    logic [7:0] analog_output_b_function;
    logic [7:0] digital_output_one_function;
    logic [7:0] digital_output_two_function;
  } dnd_fcode_t;

  typedef struct packed {
    logic        run;
    logic        reverse;
    logic        zero_speed;
    logic [15:0] freq;
    logic [15:0] opcmd;
    logic        alarm_clear;
    logic [15:0] ao_a;
    logic [15:0] ao_b;
    logic        do_one;
    logic        do_two;
    logic        rd_req;
    logic [15:0] rd_code;
    logic        wr_req;
    logic [15:0] wr_code;
    logic [15:0] wr_data;
  } dnd_drv_t;
endpackage

/* hw/dnd_decoder.sv */
// APB-facing network input decoder driving the inverter control core
`timescale 1ns/10ps

// Overview of operation
// R1: Setpoint state 0 stops, state 1 runs at value percent, 0% is zero speed.
// R2: After reset the setpoint holds state invalid and value zero.
// R3: Frequency equals setpoint percent times scale percent times nominal frequency.
// R4: Any new factor recomputes and replaces the frequency, running or stopped.
// R5: With setpoint state invalid no recomputation happens.
// R6: Setpoint and direct frequency: the most recent one wins.
// R7: Setpoint run and frequency apply only when link selection is 3.
// R8: Signed scale sets rotation direction and frequency factor.
// R9: The invalid scale code is discarded, previous scale kept.
// R10: Scale starts at the default scale property value.
// R11: Command word bits map run, X1..X9, terminals and alarm reset; reset zero.
// R12: Alarm reset bit falling from one to zero clears inverter alarms.
// R13: Command word and forward terminal apply only for link selection 2 or 3.
// R14: Direct frequency in 0.1 Hz steps, valid up to 400.0 Hz, reset 0.
// R15: Direct frequency applies only for link selection 1 or 3.
// R16: Read code selects the parameter returned on the read result.
// R17: Write value goes into the parameter named by the write code.
// R18: Analog command valid 0 to 110 percent; invalid codes are ignored.
// R19: Analog terminal follows command only when its function code is 10.
// R20: Each digital output follows its command only when function code is 27.
// R21: Digital output and forward terminal commands start at value 0, state 0.
// R22: Motor runs if forward terminal or setpoint run is on.
module dnd_decoder (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire dnd_pkg::dnd_fcode_t fcode,
  input  wire logic [15:0]        read_result_value,
  output dnd_pkg::dnd_drv_t       drv
);

  typedef struct packed {
    logic [7:0]        sp_state;
    logic [7:0]        sp_value;
    logic [15:0]       scale;
    logic [15:0]       nom;
    logic [15:0]       defscale;
    logic [7:0]        link_prop;
    logic [15:0]       opcmd;
    logic [15:0]       freq_direct;
    logic [15:0]       rd_code;
    logic [15:0]       wr_code;
    logic [15:0]       wr_data;
    logic [15:0]       ao_cmd;
    logic [15:0]       do_one_cmd;
    logic [15:0]       do_two_cmd;
    logic [15:0]       fwd_cmd;
    logic [15:0]       freq_cmd;
    logic              reverse;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    dnd_pkg::dnd_drv_t drv;
  } dnd_state_t;

  dnd_state_t q;
  dnd_state_t next_q;

  // Link selection from card property or inverter code
  function automatic logic link_is(input logic [7:0] prop,
                                   input logic [7:0] code,
                                   input logic [7:0] sel);
    return (prop == sel) || (code == sel);
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= dnd_pkg::OFS_STATUS);
  endfunction

  // Switch-type input: on only with state 1
  function automatic logic sw_on(input logic [15:0] sw);
    return sw[15:8] == dnd_pkg::SW_ON;
  endfunction

  // Value in 0.5 % steps, scale in 0.005 % steps, nominal in 0.1 Hz
  function automatic logic [15:0] calc_freq(input logic [7:0]  v,
                                            input logic [15:0] s,
                                            input logic [15:0] n);
    logic [15:0] mag;
    logic [39:0] prod;
    logic [39:0] quo;
    mag  = s[15] ? 16'(-s) : s;
    prod = 40'(v) * 40'(mag) * 40'(n);
    quo  = prod / dnd_pkg::FREQ_DIV;
    if (quo > 40'(dnd_pkg::FREQ_MAX)) begin
      return dnd_pkg::FREQ_MAX;
    end
    return quo[15:0];
  endfunction

  logic        setup;
  logic        wr_en;
  logic        lf_all;
  logic        lf_op;
  logic        lf_freq;
  logic [15:0] wd;

  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && q.pready && !q.pslverr;
  assign wd      = pwdata[15:0];
  assign lf_all  = link_is(q.link_prop, fcode.link_function_code,
                           dnd_pkg::LF_ALL);
  assign lf_op   = link_is(q.link_prop, fcode.link_function_code,
                           dnd_pkg::LF_OPCMD) || lf_all;
  assign lf_freq = link_is(q.link_prop, fcode.link_function_code,
                           dnd_pkg::LF_FREQ) || lf_all;

  always_comb begin
    logic recalc;
    logic wr_lo;
    logic wr_hi;
    recalc = 1'b0;
    next_q = q;
    wr_lo  = wr_en && pstrb[0];
    wr_hi  = wr_en && pstrb[1];
    next_q.drv.alarm_clear = 1'b0;
    next_q.drv.rd_req      = 1'b0;
    next_q.drv.wr_req      = 1'b0;

    // Register writes land at the access edge that sees pready
    if (wr_lo && wr_hi) begin
      unique case (paddr)
        dnd_pkg::OFS_SPD: begin
          next_q.sp_value = wd[7:0];
          next_q.sp_state = wd[15:8];
          recalc = 1'b1; // R4
        end
        dnd_pkg::OFS_SCALE: begin
          if (wd != dnd_pkg::SCALE_BAD) begin // R9
            next_q.scale = wd; // R8
            recalc = 1'b1; // R4
          end
        end
        dnd_pkg::OFS_NOM: begin
          next_q.nom = wd;
          recalc = 1'b1; // R4
        end
        dnd_pkg::OFS_DEFSCALE: next_q.defscale = wd;
        dnd_pkg::OFS_LINK: next_q.link_prop = wd[7:0];
        dnd_pkg::OFS_OPCMD: begin
          next_q.opcmd = wd; // R11
          // Clear only on the falling edge of the alarm reset bit
          if (lf_op && q.opcmd[dnd_pkg::ALM_BIT] &&
              !wd[dnd_pkg::ALM_BIT]) begin
            next_q.drv.alarm_clear = 1'b1; // R12
          end
        end
        dnd_pkg::OFS_FREQ: begin
          next_q.freq_direct = wd; // R14
          if (lf_freq) begin // R15
            // Direct value wins as the latest arrival
            next_q.freq_cmd = (wd > dnd_pkg::FREQ_MAX) ?
                              dnd_pkg::FREQ_MAX : wd; // R6 R14
          end
        end
        dnd_pkg::OFS_RDCODE: begin
          next_q.rd_code    = wd;
          next_q.drv.rd_req = 1'b1; // R16
        end
        dnd_pkg::OFS_WRCODE: next_q.wr_code = wd;
        dnd_pkg::OFS_WRDATA: begin
          next_q.wr_data    = wd;
          next_q.drv.wr_req = 1'b1; // R17
        end
        dnd_pkg::OFS_AO: begin
          // Negative or above 110 % counts as invalid
          if (wd <= dnd_pkg::AO_MAX) begin
            next_q.ao_cmd = wd; // R18
          end
        end
        dnd_pkg::OFS_DO1: next_q.do_one_cmd = wd;
        dnd_pkg::OFS_DO2: next_q.do_two_cmd = wd;
        dnd_pkg::OFS_FWD: next_q.fwd_cmd = wd;
        default: ;
      endcase
    end

    // Recompute from the freshly written factors
    if (recalc && lf_all &&
        next_q.sp_state != dnd_pkg::SW_INVALID) begin // R5 R7
      next_q.freq_cmd = calc_freq(next_q.sp_value, next_q.scale,
                                  next_q.nom); // R3 R6
      next_q.reverse  = next_q.scale[15]; // R8
    end

    // Read data is captured in the setup cycle
    next_q.pready  = setup;
    next_q.pslverr = setup && !addr_hit(paddr);
    next_q.prdata  = 32'h0000_0000;
    if (setup && !pwrite) begin
      unique case (paddr)
        dnd_pkg::OFS_SPD:
          next_q.prdata = {16'h0000, q.sp_state, q.sp_value};
        dnd_pkg::OFS_SCALE:    next_q.prdata = {16'h0000, q.scale};
        dnd_pkg::OFS_NOM:      next_q.prdata = {16'h0000, q.nom};
        dnd_pkg::OFS_DEFSCALE: next_q.prdata = {16'h0000, q.defscale};
        dnd_pkg::OFS_LINK:
          next_q.prdata = {24'h00_0000, q.link_prop};
        dnd_pkg::OFS_OPCMD:    next_q.prdata = {16'h0000, q.opcmd};
        dnd_pkg::OFS_FREQ:     next_q.prdata = {16'h0000, q.freq_direct};
        dnd_pkg::OFS_RDCODE:   next_q.prdata = {16'h0000, q.rd_code};
        dnd_pkg::OFS_RDVAL:
          next_q.prdata = {16'h0000, read_result_value}; // R16
        dnd_pkg::OFS_WRCODE:   next_q.prdata = {16'h0000, q.wr_code};
        dnd_pkg::OFS_WRDATA:   next_q.prdata = {16'h0000, q.wr_data};
        dnd_pkg::OFS_AO:       next_q.prdata = {16'h0000, q.ao_cmd};
        dnd_pkg::OFS_DO1:      next_q.prdata = {16'h0000, q.do_one_cmd};
        dnd_pkg::OFS_DO2:      next_q.prdata = {16'h0000, q.do_two_cmd};
        dnd_pkg::OFS_FWD:      next_q.prdata = {16'h0000, q.fwd_cmd};
        dnd_pkg::OFS_STATUS:
          next_q.prdata = {13'h0, q.drv.zero_speed, q.drv.reverse,
                           q.drv.run, q.freq_cmd};
        default: ;
      endcase
    end

    // Drive-side outputs follow the held inputs one cycle later; rd_code, wr_code and wr_data go out with their request pulse
    next_q.drv.run = (lf_all && sw_on({q.sp_state, q.sp_value})) ||
                     (lf_op && sw_on(q.fwd_cmd)); // R1 R7 R13 R22
    next_q.drv.zero_speed = lf_all && q.sp_state == dnd_pkg::SW_ON &&
                            q.sp_value == 8'h00; // R1
    next_q.drv.reverse = q.reverse; // R8
    next_q.drv.freq    = q.freq_cmd;
    next_q.drv.opcmd   = lf_op ? q.opcmd : 16'h0000; // R13
    next_q.drv.ao_a    =
      (fcode.analog_output_a_function == dnd_pkg::FN_AO) ?
      q.ao_cmd : 16'h0000; // R19
    next_q.drv.ao_b    =
      (fcode.analog_output_b_function == dnd_pkg::FN_AO) ?
      q.ao_cmd : 16'h0000; // R19
    next_q.drv.do_one  = sw_on(q.do_one_cmd) &&
      fcode.digital_output_one_function == dnd_pkg::FN_DO; // R20
    next_q.drv.do_two  = sw_on(q.do_two_cmd) &&
      fcode.digital_output_two_function == dnd_pkg::FN_DO; // R20
    next_q.drv.rd_code = q.rd_code;
    next_q.drv.wr_code = q.wr_code;
    next_q.drv.wr_data = q.wr_data;
    if (next_q.drv.rd_req) begin
      next_q.drv.rd_code = next_q.rd_code;
    end
    if (next_q.drv.wr_req) begin
      next_q.drv.wr_code = next_q.wr_code;
      next_q.drv.wr_data = next_q.wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q             <= '0;
      q.sp_state    <= dnd_pkg::RST_SP_STATE; // R2
      q.sp_value    <= dnd_pkg::RST_SP_VALUE; // R2
      q.scale       <= dnd_pkg::RST_DEFSCALE; // R10
      q.defscale    <= dnd_pkg::RST_DEFSCALE; // R10
      q.nom         <= dnd_pkg::RST_NOM;
      q.link_prop   <= dnd_pkg::RST_LINK;
      q.opcmd       <= dnd_pkg::RST_ZERO; // R11
      q.freq_direct <= dnd_pkg::RST_ZERO; // R14
      q.do_one_cmd  <= dnd_pkg::RST_ZERO; // R21
      q.do_two_cmd  <= dnd_pkg::RST_ZERO; // R21
      q.fwd_cmd     <= dnd_pkg::RST_ZERO; // R21
    end else begin
      q <= next_q;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign drv     = q.drv;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  a_apb_ready_one: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single access cycle");

  a_alarm_clear_fall: assert property ( // R12
    wr_en && pstrb[1:0] == 2'b11 && paddr == dnd_pkg::OFS_OPCMD &&
    lf_op && q.opcmd[dnd_pkg::ALM_BIT] && !pwdata[dnd_pkg::ALM_BIT]
    |=> drv.alarm_clear ##1 !drv.alarm_clear)
    else $error("alarm clear pulse missing");

  a_invalid_no_calc: assert property ( // R5
    wr_en && paddr == dnd_pkg::OFS_SCALE &&
    q.sp_state == dnd_pkg::SW_INVALID |=> $stable(q.freq_cmd))
    else $error("frequency recomputed while setpoint invalid");

  a_scale_bad_kept: assert property ( // R9
    wr_en && paddr == dnd_pkg::OFS_SCALE &&
    pwdata[15:0] == dnd_pkg::SCALE_BAD |=> $stable(q.scale))
    else $error("invalid scale code was stored");

  a_direct_freq_last: assert property ( // R6
    s_access ##0 (wr_en && pstrb[1:0] == 2'b11 && lf_freq &&
    paddr == dnd_pkg::OFS_FREQ && pwdata[15:0] <= dnd_pkg::FREQ_MAX)
    |=> ##1 drv.freq == $past(pwdata[15:0], 2))
    else $error("direct frequency not applied");

  a_freq_ceiling: assert property (drv.freq <= dnd_pkg::FREQ_MAX) // R14
    else $error("frequency above drive limit");

  a_ao_valid_range: assert property (q.ao_cmd <= dnd_pkg::AO_MAX) // R18
    else $error("analog command outside valid range");

  a_do_gate_code: assert property ( // R20
    drv.do_one |-> $past(fcode.digital_output_one_function) ==
    dnd_pkg::FN_DO)
    else $error("digital output one on without function 27");

  a_opcmd_gate: assert property ( // R13
    drv.opcmd != 16'h0000 |-> $past(lf_op))
    else $error("command word applied without link 2 or 3");

  a_run_source: assert property ( // R22
    drv.run |-> $past((lf_all && sw_on({q.sp_state, q.sp_value})) ||
    (lf_op && sw_on(q.fwd_cmd))))
    else $error("run without setpoint or forward command");

  a_bad_addr_err: assert property (
    s_setup ##0 !addr_hit(paddr) |=> pready && pslverr)
    else $error("unmapped address without error response");

  a_ao_same_level: assert property ( // R19
    fcode.analog_output_a_function == dnd_pkg::FN_AO &&
    fcode.analog_output_b_function == dnd_pkg::FN_AO
    |=> drv.ao_a == drv.ao_b)
    else $error("analog terminals carry different levels");

  a_do_two_gate: assert property ( // R20
    drv.do_two |-> $past(fcode.digital_output_two_function) ==
    dnd_pkg::FN_DO)
    else $error("digital output two on without function 27");

  a_req_pulse_one: assert property ( // R16 R17
    drv.rd_req || drv.wr_req |=> !drv.rd_req && !drv.wr_req)
    else $error("request pulse longer than one cycle");

  a_zero_needs_run: assert property (drv.zero_speed |-> drv.run) // R1
    else $error("zero speed without run command");

  a_wr_req_data: assert property ( // R17
    drv.wr_req |-> drv.wr_data == $past(pwdata[15:0]))
    else $error("write pulse carries wrong data");

  a_rd_req_code: assert property ( // R16
    drv.rd_req |-> drv.rd_code == $past(pwdata[15:0]))
    else $error("read pulse carries wrong code");

  a_freq_clamp: assert property ( // R14
    s_access ##0 (wr_en && pstrb[1:0] == 2'b11 && lf_freq &&
    paddr == dnd_pkg::OFS_FREQ && pwdata[15:0] > dnd_pkg::FREQ_MAX)
    |=> ##1 drv.freq == dnd_pkg::FREQ_MAX)
    else $error("direct frequency above limit not clamped");

  a_ao_bad_kept: assert property ( // R18
    wr_en && paddr == dnd_pkg::OFS_AO &&
    pwdata[15:0] > dnd_pkg::AO_MAX |=> $stable(q.ao_cmd))
    else $error("invalid analog command was stored");

endmodule

/* dv/dnd_core_model.sv */
// Inverter core stand-in holding a small function code table
`timescale 1ns/10ps
module dnd_core_model (
  input  wire logic              pclk,
  input  wire dnd_pkg::dnd_drv_t drv,
  output logic [15:0]            read_result_value
);
  logic [15:0] tbl [16];

  // Table seeded with distinct words so a wrong index shows up
  initial begin
    for (int i = 0; i < 16; i++) tbl[i] = 16'h0a00 + 16'(i);
    read_result_value = 16'h0000;
  end

  always @(posedge pclk) begin
    if (drv.wr_req) tbl[drv.wr_code[3:0]] <= drv.wr_data;
    if (drv.rd_req) read_result_value <= tbl[drv.rd_code[3:0]];
  end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the drive network input decoder
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata;
  logic [3:0]         pstrb;
  logic [15:0]        rrv, d;
  dnd_pkg::dnd_fcode_t fc;
  dnd_pkg::dnd_drv_t  drv;
  int n_fail, n_compared, seed, r, sp_st, sp_val, scl, nom, lp, opc, frq;
  int rev, ao, d1, d2, fw, rdc, wrc, wrd, rv, ea, er, ew;
  int pm [16];
  logic [7:0] ofs [8] = '{dnd_pkg::OFS_SPD, dnd_pkg::OFS_SCALE,
    dnd_pkg::OFS_NOM, dnd_pkg::OFS_FREQ, dnd_pkg::OFS_AO,
    dnd_pkg::OFS_DO1, dnd_pkg::OFS_FWD, dnd_pkg::OFS_OPCMD};

  dnd_decoder DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fcode(fc), .read_result_value(rrv), .drv(drv));
  dnd_core_model core (.pclk(pclk), .drv(drv), .read_result_value(rrv));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic bit lk(int a, int b);
    return lp == a || lp == b || fc.link_function_code == a ||
      fc.link_function_code == b;
  endfunction

  function automatic int erun();
    return int'(lk(3, 3) && sp_st == 1 || lk(2, 3) && fw == 1);
  endfunction

  function automatic int ezs();
    return int'(lk(3, 3) && sp_st == 1 && sp_val == 0);
  endfunction

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic mdl_reset();
    sp_st = 255; sp_val = 0; scl = 20000; nom = 500; lp = 0; opc = 0;
    frq = 0; rev = 0; ao = 0; d1 = 0; d2 = 0; fw = 0;
    rdc = 0; wrc = 0; wrd = 0;
  endtask

  task automatic mdl_wr(logic [7:0] a, logic [15:0] v);
    bit rc;
    longint f;
    rc = 0; ea = 0; er = 0; ew = 0;
    case (a)
      dnd_pkg::OFS_SPD: begin
        sp_st = v[15:8];
        sp_val = v[7:0];
        rc = 1;
      end
      dnd_pkg::OFS_SCALE: begin
        if (v != 16'h7fff) begin
          scl = int'($signed(v));
          rc = 1;
        end
      end
      dnd_pkg::OFS_NOM: begin
        nom = v;
        rc = 1;
      end
      dnd_pkg::OFS_LINK: lp = v[7:0];
      dnd_pkg::OFS_OPCMD: begin
        ea = int'(opc[15] && !v[15] && lk(2, 3));
        opc = v;
      end
      dnd_pkg::OFS_FREQ: if (lk(1, 3)) frq = v > 4000 ? 4000 : v;
      dnd_pkg::OFS_RDCODE: begin
        rdc = v;
        er = 1;
        rv = pm[rdc % 16];
      end
      dnd_pkg::OFS_WRCODE: wrc = v;
      dnd_pkg::OFS_WRDATA: begin
        wrd = v;
        ew = 1;
        pm[wrc % 16] = wrd;
      end
      dnd_pkg::OFS_AO: if (v <= 16'h55f0) ao = v;
      dnd_pkg::OFS_DO1: d1 = v[15:8];
      dnd_pkg::OFS_DO2: d2 = v[15:8];
      dnd_pkg::OFS_FWD: fw = v[15:8];
      default: ;
    endcase
    if (rc && lk(3, 3) && sp_st != 255) begin
      f = longint'(sp_val) * (scl < 0 ? -scl : scl) * nom / 4000000;
      frq = f > 4000 ? 4000 : int'(f);
      rev = int'(scl < 0);
    end
  endtask

  task automatic chk_drv();
    `CHK("run", erun(), drv.run)
    `CHK("reverse", rev, drv.reverse)
    `CHK("zero_speed", ezs(), drv.zero_speed)
    `CHK("freq", frq, drv.freq)
    `CHK("opcmd", lk(2, 3) ? opc : 0, drv.opcmd)
    `CHK("ao_a", fc.analog_output_a_function == 10 ? ao : 0, drv.ao_a)
    `CHK("ao_b", fc.analog_output_b_function == 10 ? ao : 0, drv.ao_b)
    `CHK("do_one", int'(fc.digital_output_one_function == 27 && d1 == 1),
      drv.do_one)
    `CHK("do_two", int'(fc.digital_output_two_function == 27 && d2 == 1),
      drv.do_two)
  endtask

  // Entered just after a rising edge; returns at the edge pready was seen
  task automatic apb(logic w, logic [7:0] a, logic [15:0] v,
                     output logic [31:0] q, output logic e);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, v};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      test_done();
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] v);
    logic [31:0] q;
    logic e;
    mdl_wr(a, v);
    apb(1'b1, a, v, q, e);
    #1;
    `CHK("alarm_clear", ea, drv.alarm_clear)
    `CHK("rd_req", er, drv.rd_req)
    `CHK("wr_req", ew, drv.wr_req)
    if (er) `CHK("rd_code", rdc, drv.rd_code)
    if (ew) `CHK("wr_data", {16'(wrc), 16'(wrd)},
      {drv.wr_code, drv.wr_data})
    repeat (2) @(posedge pclk);
    #1 chk_drv();
    @(posedge pclk);
  endtask

  task automatic rd(logic [7:0] a, int x, bit err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 16'h0000, q, e);
    `CHK("pslverr", err, e)
    if (!err) `CHK("prdata", x, q)
    @(posedge pclk);
  endtask

  initial begin
    seed = 7; n_fail = 0; n_compared = 0; rv = 0;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 4'hf; fc = '0; presetn = 0;
    for (int i = 0; i < 16; i++) pm[i] = 16'h0a00 + i;
    mdl_reset();
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 chk_drv();
    @(posedge pclk);
    rd(dnd_pkg::OFS_SPD, 'hff00, 0);
    rd(dnd_pkg::OFS_SCALE, 'h4e20, 0);
    rd(8'h40, 0, 1);
    $display("reset test done");
    wr(dnd_pkg::OFS_LINK, 16'h0003);
    wr(dnd_pkg::OFS_NOM, 16'd1000);
    wr(dnd_pkg::OFS_SPD, 16'h0190);
    wr(dnd_pkg::OFS_FREQ, 16'd1234);
    wr(dnd_pkg::OFS_SCALE, 16'hec78);
    wr(dnd_pkg::OFS_SCALE, 16'h7fff);
    rd(dnd_pkg::OFS_STATUS,
      frq | erun() << 16 | rev << 17 | ezs() << 18, 0);
    wr(dnd_pkg::OFS_FREQ, 16'd4500);
    wr(dnd_pkg::OFS_SPD, 16'h0100);
    wr(dnd_pkg::OFS_SPD, 16'h0000);
    wr(dnd_pkg::OFS_LINK, 16'h0000);
    $display("frequency test done");
    for (int l = 0; l < 4; l++) begin
      fc.link_function_code <= 8'(l);
      @(posedge pclk);
      wr(dnd_pkg::OFS_OPCMD, 16'h8003);
      wr(dnd_pkg::OFS_OPCMD, 16'h0003);
      wr(dnd_pkg::OFS_FWD, 16'h0100);
      wr(dnd_pkg::OFS_FREQ, 16'(100 * l + 5));
      wr(dnd_pkg::OFS_SPD, 16'h01c8);
      wr(dnd_pkg::OFS_FWD, 16'h0000);
    end
    $display("link test done");
    fc <= '{8'h03, 8'h0a, 8'h09, 8'h1b, 8'h1a};
    @(posedge pclk);
    wr(dnd_pkg::OFS_AO, 16'h55f0);
    wr(dnd_pkg::OFS_AO, 16'h55f1);
    wr(dnd_pkg::OFS_AO, 16'h7fff);
    wr(dnd_pkg::OFS_DO1, 16'h0100);
    wr(dnd_pkg::OFS_DO2, 16'h0100);
    fc <= '{8'h03, 8'h0a, 8'h0a, 8'h1b, 8'h1b};
    repeat (3) @(posedge pclk);
    #1 chk_drv();
    @(posedge pclk);
    wr(dnd_pkg::OFS_WRCODE, 16'h0003);
    wr(dnd_pkg::OFS_WRDATA, 16'hbeef);
    wr(dnd_pkg::OFS_RDCODE, 16'h0003);
    rd(dnd_pkg::OFS_RDVAL, rv, 0);
    $display("output test done");
    for (int i = 0; i < 24; i++) begin
      r = xs();
      fc.link_function_code <= 8'(r[1:0]);
      @(posedge pclk);
      d = 16'(xs());
      if (ofs[r[4:2]] == dnd_pkg::OFS_SPD) begin
        d[15:8] = r[6] ? 8'h01 : (r[5] ? 8'hff : 8'h00);
        d[7:0] = d[7:0] % 8'd201;
      end
      wr(ofs[r[4:2]], d);
    end
    $display("random test done");
    presetn <= 1'b0;
    mdl_reset();
    @(posedge pclk);
    #1 chk_drv();
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(dnd_pkg::OFS_SPD, 'hff00, 0);
    $display("second reset test done");
    test_done();
  end
endmodule
